/* core/orcs_regs.sv */
/*
  Register bank with transmit retry limits, compare-swap access to the four
  bus management resources, configuration ROM header and interrupt logic.
  Assumes an APB master on CLK_SYS_I, transmit engines on the same clock,
  and a serial-ROM reader that presents the CRC with a one-cycle valid.
*/
// Summary of operation
// RULE_01: Second retry limit bits 31:29 always read as zero.
// RULE_02: Cycle limit bits 28:16 always read as zero.
// RULE_03: Physical response unit retries on busy or data error up to limit.
// RULE_04: Response unit retries on busy or data error up to its limit.
// RULE_05: Request unit retries on busy or data error up to its limit.
// RULE_06: Retry bits 15:12 and swap control bits 30:2 read as zero.
// RULE_07: Swap data is stored into the resource only on a matching compare.
// RULE_08: Swap compare value is checked against the selected resource.
// RULE_09: Swap complete flag in bit 31 sets when the swap finishes.
// RULE_10: Any write to swap control clears the complete flag; a write during SW_FINISH leaves it set.
// RULE_11: Select 0..3 picks manager id, bandwidth, channels high, channels low.
// RULE_12: ROM header answers serial bus reads at the fixed first ROM address.
// RULE_13: Software keeps length fields valid while the link is active.
// RULE_14: Software keeps the CRC field valid while the link is active.
// RULE_15: CRC field loads from the serial ROM when one is present.
// RULE_16: Read-only flag shows serial ROM presence; loading follows reset.
// RULE_17: Control write starts the swap; old value readable before flag.
// RULE_18: Retries counted per packet; stop at limit; zero limit means none.
`timescale 1ns/1ns
module orcs_regs
(
   input  wire logic                           CLK_SYS_I,
   input  wire logic                           RST_N_I,
   // APB slave
   input  wire logic                           PSEL_I,
   input  wire logic                           PENABLE_I,
   input  wire logic                           PWRITE_I,
   input  wire logic [7:0]                     PADDR_I,
   input  wire logic [31:0]                    PWDATA_I,
   output logic                                PREADY_O,
   output logic [31:0]                         PRDATA_O,
   output logic                                PSLVERR_O,
   // Transmit engines: 0 request, 1 response, 2 physical response
   input  wire orcs_pkg::orcs_tx_ack_type [2:0] TX_ACK_I,
   output orcs_pkg::orcs_tx_stat_type [2:0]    TX_STAT_O,
   // Serial bus quadlet read of the ROM header
   input  wire logic                           CFG_RD_REQ_I,
   input  wire logic [47:0]                    CFG_RD_ADDR_I,
   output logic                                CFG_RD_HIT_O,
   output logic [31:0]                         CFG_RD_DATA_O,
   // Serial ROM
   input  wire logic                           SROM_PRESENT_I,
   input  wire logic                           SROM_CRC_VALID_I,
   input  wire logic [15:0]                    SROM_CRC_I,
   // Status
   output logic                                LINK_ACTIVE_O,
   output logic                                IRQ_O
);
   import orcs_pkg::*;

   // ==========================================================
   // Declarations
   logic                      pready;
   logic [31:0]               prdata;
   logic                      pslverr;
   logic [11:0]               retry_limits;
   logic [31:0]               swap_data;
   logic [31:0]               swap_cmp;
   logic                      swap_done;
   logic [1:0]                swap_sel;
   logic [31:0]               rom_hdr;
   logic [31:0]               mgmt_res [4];
   logic [31:0]               swap_old;
   orcs_swap_state_type       swap_state;
   logic [IRQ_WIDTH-1:0]      irq_status;
   logic [IRQ_WIDTH-1:0]      irq_mask;
   logic                      link_active;
   logic                      rom_present;
   logic                      strap_meta;
   logic                      strap_sync;
   logic [1:0]                strap_cnt;
   logic                      strap_taken;
   logic [3:0]                retry_cnt [3];
   logic [2:0]                tx_busy;
   orcs_tx_stat_type [2:0]    tx_stat;
   logic                      cfg_hit;
   logic [31:0]               cfg_data;
   logic                      irq;
   logic                      access;
   logic                      wr_en;
   logic                      rd_done;
   logic [IRQ_WIDTH-1:0]      next_irq_set;
   logic [31:0]               next_prdata;
   logic                      next_pslverr;

   // Limit of one transmit engine taken from the retry register
   function automatic logic [3:0] unit_limit(input logic [11:0] lim, input int unit);
      logic [3:0] val;
      val = 4'h0;
      unique case (unit)
         0: val = lim[RETRY_REQ_LSB +: 4];                  // RULE_05
         1: val = lim[RETRY_RESP_LSB +: 4];                 // RULE_04
         default: val = lim[RETRY_PHYS_LSB +: 4];           // RULE_03
      endcase
      return val;
   endfunction

   // Address match helper for the decode
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction

   // ==========================================================
   // APB handshake: one wait state, writes land on the completing edge
   assign access  = PSEL_I && PENABLE_I;
   assign wr_en   = access && pready && PWRITE_I;
   assign rd_done = access && pready && !PWRITE_I;

   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
      begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else
      begin
         pready  <= access && !pready;
         prdata  <= next_prdata;
         pslverr <= next_pslverr;
      end
   end

   // Read multiplexer; reserved and dual-phase fields are forced low
   always_comb
   begin
      next_prdata  = 32'h0000_0000;
      next_pslverr = 1'b0;
      if (access && !pready)
      begin
         if (hit(PADDR_I, OFS_VERSION))
         begin
            next_prdata = VERSION_RST;
            next_prdata[ROM_PRESENT_BIT] = rom_present;      // RULE_16
         end
         else if (hit(PADDR_I, OFS_RETRY))
            next_prdata = {16'h0000, 4'h0, retry_limits};    // RULE_01 RULE_02 RULE_06
         else if (hit(PADDR_I, OFS_SWAP_DATA))
            next_prdata = swap_data;
         else if (hit(PADDR_I, OFS_SWAP_CMP))
            next_prdata = swap_cmp;
         else if (hit(PADDR_I, OFS_SWAP_CTRL))
            next_prdata = {swap_done, 29'h0000_0000, swap_sel}; // RULE_06
         else if (hit(PADDR_I, OFS_ROM_HDR))
            next_prdata = rom_hdr;
         else if (hit(PADDR_I, OFS_IRQ_STATUS))
            next_prdata = {27'h000_0000, irq_status};
         else if (hit(PADDR_I, OFS_IRQ_MASK))
            next_prdata = {27'h000_0000, irq_mask};
         else if (hit(PADDR_I, OFS_LINK_CTRL))
            next_prdata = {31'h0000_0000, link_active};
         else
            next_pslverr = 1'b1;  // Unmapped: error, data zero
      end
   end

   // ==========================================================
   // Software-written configuration
   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
      begin
         retry_limits <= RETRY_RST[11:0];
         swap_cmp     <= 32'h0000_0000;
         swap_sel     <= CTRL_RST[1:0];
         irq_mask     <= {IRQ_WIDTH{1'b0}};
         link_active  <= 1'b0;
      end
      else if (wr_en)
      begin
         if (hit(PADDR_I, OFS_RETRY))
            retry_limits <= PWDATA_I[RETRY_WR_MSB:0];
         if (hit(PADDR_I, OFS_SWAP_CMP))
            swap_cmp <= PWDATA_I;                            // RULE_08
         if (hit(PADDR_I, OFS_SWAP_CTRL))
            swap_sel <= PWDATA_I[SWAP_SEL_MSB:0];            // RULE_11
         if (hit(PADDR_I, OFS_IRQ_MASK))
            irq_mask <= PWDATA_I[IRQ_WIDTH-1:0];
         if (hit(PADDR_I, OFS_LINK_CTRL))
            link_active <= PWDATA_I[LINK_ACTIVE_BIT];
      end
   end

   // ==========================================================
   // Compare-swap engine; resources are indexed by the select code
   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
      begin
         swap_state <= SW_IDLE;
         swap_old   <= 32'h0000_0000;
         for (int i = 0; i < 4; i++)
            mgmt_res[i] <= 32'h0000_0000;
      end
      else
      begin
         unique case (swap_state)
            SW_IDLE:
               if (wr_en && hit(PADDR_I, OFS_SWAP_CTRL))
                  swap_state <= SW_EXEC;                     // RULE_17
            SW_EXEC:
            begin
               swap_old <= mgmt_res[swap_sel];               // RULE_11
               if (mgmt_res[swap_sel] == swap_cmp)           // RULE_08
                  mgmt_res[swap_sel] <= swap_data;           // RULE_07
               swap_state <= SW_FINISH;
            end
            SW_FINISH:
               swap_state <= SW_IDLE;
         endcase
      end
   end

   // Swap data: software value, replaced by the old content after a swap
   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
         swap_data <= 32'h0000_0000;
      else if (swap_state == SW_EXEC)
         swap_data <= mgmt_res[swap_sel];                    // RULE_17
      else if (wr_en && hit(PADDR_I, OFS_SWAP_DATA))
         swap_data <= PWDATA_I;
   end

   // Complete flag; hardware set beats a software write in the same cycle
   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
         swap_done <= CTRL_RST[SWAP_DONE_BIT];
      else if (swap_state == SW_FINISH)
         swap_done <= 1'b1;                                  // RULE_09
      else if (wr_en && hit(PADDR_I, OFS_SWAP_CTRL))
         swap_done <= 1'b0;                                  // RULE_10
   end

   // ==========================================================
   // Serial ROM strap, caught a few cycles after reset release
   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
      begin
         strap_meta  <= 1'b0;
         strap_sync  <= 1'b0;
         strap_cnt   <= 2'h0;
         strap_taken <= 1'b0;
         rom_present <= 1'b0;
      end
      else
      begin
         strap_meta <= SROM_PRESENT_I;
         strap_sync <= strap_meta;
         if (!strap_taken)
         begin
            if (strap_cnt == STRAP_DELAY)
            begin
               rom_present <= strap_sync;                    // RULE_16
               strap_taken <= 1'b1;
            end
            else
               strap_cnt <= strap_cnt + 2'h1;
         end
      end
   end

   // ROM header; CRC field is overwritten by a ROM load when present
   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
         rom_hdr <= ROM_HDR_RST;
      else
      begin
         if (wr_en && hit(PADDR_I, OFS_ROM_HDR))
            rom_hdr <= PWDATA_I;
         if (SROM_CRC_VALID_I && rom_present)
            rom_hdr[15:0] <= SROM_CRC_I;                     // RULE_15
      end
   end

   // Serial bus view of the header, answered one cycle after the request
   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
      begin
         cfg_hit  <= 1'b0;
         cfg_data <= 32'h0000_0000;
      end
      else
      begin
         cfg_hit  <= CFG_RD_REQ_I && (CFG_RD_ADDR_I == ROM_HDR_BUS_ADDR); // RULE_12
         cfg_data <= (CFG_RD_REQ_I && (CFG_RD_ADDR_I == ROM_HDR_BUS_ADDR)) ? rom_hdr : 32'h0000_0000;
      end
   end

   // ==========================================================
   // Retry counters, one per engine; a start rearms the count
   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
      begin
         tx_busy <= 3'h0;
         tx_stat <= '0;
         for (int u = 0; u < 3; u++)
            retry_cnt[u] <= 4'h0;
      end
      else
      begin
         for (int u = 0; u < 3; u++)
         begin
            tx_stat[u] <= '0;
            if (TX_ACK_I[u].start)
            begin
               tx_busy[u]   <= 1'b1;
               retry_cnt[u] <= 4'h0;                         // RULE_18
            end
            else if (tx_busy[u] && TX_ACK_I[u].ack_valid)
            begin
               if (!TX_ACK_I[u].ack_retry)
               begin
                  tx_busy[u]            <= 1'b0;
                  tx_stat[u].finished   <= 1'b1;
               end
               else if (retry_cnt[u] < unit_limit(retry_limits, u)) // RULE_03 RULE_04 RULE_05
               begin
                  retry_cnt[u]          <= retry_cnt[u] + 4'h1;
                  tx_stat[u].resend     <= 1'b1;
               end
               else
               begin
                  tx_busy[u]            <= 1'b0;             // RULE_18
                  tx_stat[u].gave_up    <= 1'b1;
               end
            end
         end
      end
   end

   // ==========================================================
   // Interrupts: sticky events, cleared by reading status; set wins
   always_comb
   begin
      next_irq_set = {IRQ_WIDTH{1'b0}};
      next_irq_set[IRQ_SWAP_BIT] = (swap_state == SW_FINISH);
      for (int u = 0; u < 3; u++)
         next_irq_set[IRQ_GIVEUP_LSB + u] = tx_stat[u].gave_up;
      next_irq_set[IRQ_CRC_BIT] = SROM_CRC_VALID_I && rom_present;
   end

   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
      begin
         irq_status <= {IRQ_WIDTH{1'b0}};
         irq        <= 1'b0;
      end
      else
      begin
         if (rd_done && hit(PADDR_I, OFS_IRQ_STATUS))
            irq_status <= next_irq_set;
         else
            irq_status <= irq_status | next_irq_set;
         irq <= |(irq_status & irq_mask);
      end
   end

   // ==========================================================
   // Outputs
   assign PREADY_O      = pready;
   assign PRDATA_O      = prdata;
   assign PSLVERR_O     = pslverr;
   assign TX_STAT_O     = tx_stat;
   assign CFG_RD_HIT_O  = cfg_hit;
   assign CFG_RD_DATA_O = cfg_data;
   assign LINK_ACTIVE_O = link_active;  // RULE_13 RULE_14 software keeps header valid
   assign IRQ_O         = irq;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!RST_N_I);

   sequence s_swap_start;
      wr_en && hit(PADDR_I, OFS_SWAP_CTRL) && swap_state == SW_IDLE;
   endsequence

   sequence s_swap_run;
      swap_state == SW_EXEC ##1 swap_state == SW_FINISH ##1 swap_done;
   endsequence

   a_retry_high_zero: assert property (pready && PSEL_I && hit(PADDR_I, OFS_RETRY) |-> prdata[31:29] == 3'h0) // RULE_01
      else $error("second limit field not zero");
   a_cycle_limit_zero: assert property (pready && PSEL_I && hit(PADDR_I, OFS_RETRY) |-> prdata[28:16] == 13'h0000) // RULE_02
      else $error("cycle limit field not zero");
   a_ctrl_rsvd_zero: assert property (pready && PSEL_I && hit(PADDR_I, OFS_SWAP_CTRL) |-> prdata[30:2] == 29'h0000_0000 && prdata[15:12] == 4'h0) // RULE_06
      else $error("reserved swap control bits not zero");
   a_swap_sequence: assert property (s_swap_start |=> s_swap_run) // RULE_09
      else $error("swap did not complete in three cycles");
   a_write_clears: assert property (wr_en && hit(PADDR_I, OFS_SWAP_CTRL) && swap_state != SW_FINISH |=> !swap_done) // RULE_10
      else $error("control write left complete flag set");
   a_swap_store: assert property (swap_state == SW_EXEC && mgmt_res[swap_sel] == swap_cmp |=> mgmt_res[$past(swap_sel)] == $past(swap_data)) // RULE_07
      else $error("matching swap did not store new value");
   a_swap_keep: assert property (swap_state == SW_EXEC && mgmt_res[swap_sel] != swap_cmp |=> $stable(mgmt_res[swap_sel])) // RULE_08
      else $error("failed compare changed resource");
   a_old_value: assert property (swap_state == SW_FINISH |-> swap_data == swap_old && !swap_done) // RULE_17
      else $error("old value not visible before flag");
   a_retry_bound: assert property (tx_stat[0].resend |-> retry_cnt[0] <= retry_limits[3:0] && retry_cnt[0] != 4'h0) // RULE_18
      else $error("request retry beyond limit");
   a_rom_map: assert property (CFG_RD_REQ_I && CFG_RD_ADDR_I == ROM_HDR_BUS_ADDR |=> cfg_hit && cfg_data == $past(rom_hdr)) // RULE_12
      else $error("ROM header not presented at bus address");
   a_crc_load: assert property (SROM_CRC_VALID_I && rom_present |=> rom_hdr[15:0] == $past(SROM_CRC_I)) // RULE_15
      else $error("CRC not loaded from serial ROM");

endmodule

/* pkg/orcs_pkg.sv */
/*
  Constants and carrier types for the retry-limit, compare-swap and
  configuration ROM header register block.
  Assumes a 32-bit APB master and three same-clock transmit engines.
*/
package orcs_pkg;

   // ==========================================================
   // Register offsets (byte addresses)
   localparam logic [7:0] OFS_VERSION      = 8'h00;
   localparam logic [7:0] OFS_RETRY        = 8'h08;
   localparam logic [7:0] OFS_SWAP_DATA    = 8'h0C;
   localparam logic [7:0] OFS_SWAP_CMP     = 8'h10;
   localparam logic [7:0] OFS_SWAP_CTRL    = 8'h14;
   localparam logic [7:0] OFS_ROM_HDR      = 8'h18;
   localparam logic [7:0] OFS_IRQ_STATUS   = 8'h40;
   localparam logic [7:0] OFS_IRQ_MASK     = 8'h44;
   localparam logic [7:0] OFS_LINK_CTRL    = 8'h48;

   // ==========================================================
   // Field positions
   localparam int RETRY_REQ_LSB   = 0;
   localparam int RETRY_RESP_LSB  = 4;
   localparam int RETRY_PHYS_LSB  = 8;
   localparam int RETRY_WR_MSB    = 11;
   localparam int SWAP_DONE_BIT   = 31;
   localparam int SWAP_SEL_MSB    = 1;
   localparam int ROM_PRESENT_BIT = 24;
   localparam int LINK_ACTIVE_BIT = 0;
   localparam int IRQ_SWAP_BIT    = 0;
   localparam int IRQ_GIVEUP_LSB  = 1;
   localparam int IRQ_CRC_BIT     = 4;
   localparam int IRQ_WIDTH       = 5;

   // ==========================================================
   // Reset values and fixed figures
   localparam logic [31:0] RETRY_RST     = 32'h0000_0000;
   localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
   localparam logic [31:0] ROM_HDR_RST   = 32'h0000_0000;
   localparam logic [31:0] VERSION_RST   = 32'h0001_0000;
   localparam logic [47:0] ROM_HDR_BUS_ADDR = 48'hFFFF_F000_0400;
   localparam logic [1:0]  STRAP_DELAY   = 2'h2;

   // ==========================================================
   // Carrier types
   typedef struct packed {
      logic start;      // New packet goes out
      logic ack_valid;  // Acknowledge arrived
      logic ack_retry;  // Ack was busy or data error
   } orcs_tx_ack_type;

   typedef struct packed {
      logic resend;     // Send the packet again
      logic gave_up;    // Retries used up
      logic finished;   // Packet closed without further retry
   } orcs_tx_stat_type;

   typedef enum logic [1:0] {SW_IDLE, SW_EXEC, SW_FINISH} orcs_swap_state_type;

endpackage

/* verification/orcs_ack_model.sv */
/*
  Far-side model of the remote nodes that acknowledge the three transmit
  engines. Assumes the bench pulses go_i for one cycle per packet while
  busy_i holds the number of busy acknowledges to give before success.
*/
`timescale 1ns/1ns
module orcs_ack_model
(
   input  wire logic                             clk_i,
   input  wire logic                             rst_n_i,
   input  wire logic [2:0]                       go_i,
   input  wire logic [2:0][3:0]                  busy_i,
   input  wire logic [1:0]                       pace_i,
   input  wire orcs_pkg::orcs_tx_stat_type [2:0] stat_i,
   output orcs_pkg::orcs_tx_ack_type [2:0]       ack_o
);
   import orcs_pkg::*;
   int left [3];
   int dly  [3];
   // ==========================================================
   // Acknowledge each send after a paced delay; busy until the count runs out
   always @(posedge clk_i)
   begin
      for (int u = 0; u < 3; u++)
      begin
         orcs_tx_ack_type a;
         a = '0;
         if (!rst_n_i)
            dly[u] = 0;
         else if (go_i[u])
         begin
            a.start = 1'b1;
            left[u] = busy_i[u];
            dly[u] = pace_i + 2;
         end
         else if (stat_i[u].resend)
            dly[u] = pace_i + 2;      // Resent packet gets a fresh answer
         else if (dly[u] == 1)
         begin
            a.ack_valid = 1'b1;
            a.ack_retry = (left[u] > 0);
            left[u]--;
            dly[u] = 0;
         end
         else if (dly[u] > 1)
            dly[u]--;
         ack_o[u] <= a;               // One assignment per engine and edge
      end
   end
endmodule

/* verification/test_ohci_retry_csr_swap_regs.sv */
/*
  Self-checking bench for the retry, compare-swap and ROM header registers.
  Assumes one 25 MHz clock; drives APB, serial ROM and bus read lines.
*/
`timescale 1ns/1ns
module test_ohci_retry_csr_swap_regs;
   import orcs_pkg::*;
   logic                  clk = 1'b0;
   logic                  rst_n = 1'b0;
   logic                  psel = 1'b0;
   logic                  penable = 1'b0;
   logic                  pwrite = 1'b0;
   logic [7:0]            paddr = 8'h00;
   logic [31:0]           pwdata = 32'h0;
   logic                  pready, pslverr, irq, link, cfg_hit;
   logic [31:0]           prdata, cfg_data, rd, d, cmp, v;
   logic                  err;
   orcs_tx_ack_type [2:0]  ack;
   orcs_tx_stat_type [2:0] stat;
   logic                  strap = 1'b1;
   logic                  cfg_req = 1'b0;
   logic [47:0]           cfg_addr = 48'h0;
   logic                  crc_valid = 1'b0;
   logic [15:0]           crc = 16'h0;
   logic [2:0]            go = 3'h0;
   logic [2:0][3:0]       busy = '0;
   logic [1:0]            pace = 2'h0;
   logic [31:0]           res [4] = '{default: 32'h0};
   int                    n_mismatch = 0, n_tests = 0, cycles = 0, seed = 31975;
   int                    resends [3], gaves [3], fins [3];
   int                    u, lim, nb, mask, sel;

   always #20 clk = ~clk;
   orcs_regs i_dut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
      .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PREADY_O(pready),
      .PRDATA_O(prdata), .PSLVERR_O(pslverr), .TX_ACK_I(ack), .TX_STAT_O(stat),
      .CFG_RD_REQ_I(cfg_req), .CFG_RD_ADDR_I(cfg_addr), .CFG_RD_HIT_O(cfg_hit),
      .CFG_RD_DATA_O(cfg_data), .SROM_PRESENT_I(strap), .SROM_CRC_VALID_I(crc_valid),
      .SROM_CRC_I(crc), .LINK_ACTIVE_O(link), .IRQ_O(irq));
   orcs_ack_model i_far (.clk_i(clk), .rst_n_i(rst_n), .go_i(go), .busy_i(busy),
      .pace_i(pace), .stat_i(stat), .ack_o(ack));

   // ==========================================================
   // Status pulse counters and the hang guard
   always @(posedge clk)
   begin
      for (int i = 0; i < 3; i++)
      begin
         resends[i] += stat[i].resend;
         gaves[i] += stat[i].gave_up;
         fins[i] += stat[i].finished;
      end
      cycles++;
      if (cycles == 20000)
      begin
         n_mismatch++;
         results();
      end
   end

   // ==========================================================
   // Shared tasks
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // One APB transfer, held until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
      apb(1'b0, a, 32'h0);
      check(name, rd, exp);
      check("no slave error", err, 1'b0);
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ==========================================================
   // Main sequence
   initial
   begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      rd_chk(OFS_VERSION, VERSION_RST | 32'h0100_0000, "version");
      rd_chk(OFS_SWAP_CTRL, CTRL_RST, "control reset");
      rd_chk(OFS_RETRY, RETRY_RST, "retry reset");
      v = $random(seed);
      apb(1'b1, OFS_RETRY, v);
      rd_chk(OFS_RETRY, v & 32'h0000_0FFF, "retry fields");
      apb(1'b0, 8'h04, 32'h0);
      check("unmapped error", {31'h0, err}, 32'h1);
      check("unmapped data", rd, 32'h0);
      // Each engine: random limit, busy count, pace and mask
      for (int t = 0; t < 12; t++)
      begin
         u = t % 3;
         lim = {$random(seed)} % 4;
         nb = {$random(seed)} % 6;
         mask = {$random(seed)} % 32;
         apb(1'b1, OFS_IRQ_MASK, mask);
         apb(1'b1, OFS_RETRY, lim << (4 * u));
         resends = '{0, 0, 0};
         gaves = '{0, 0, 0};
         fins = '{0, 0, 0};
         busy[u] <= nb[3:0];
         pace <= 2'($random(seed));
         go[u] <= 1'b1;
         @(posedge clk);
         go <= 3'h0;
         while (fins[u] + gaves[u] == 0) @(negedge clk);
         repeat (2) @(negedge clk);
         check("resends", resends[u], (nb < lim) ? nb : lim);
         check("gave up", gaves[u], nb > lim);
         v = (nb > lim) ? (1 << (1 + u)) : 0;
         check("irq line", irq, |(v & mask));
         rd_chk(OFS_IRQ_STATUS, v, "irq status");
      end
      // Compare-swap on every resource, hits and misses
      apb(1'b1, OFS_IRQ_MASK, 32'h1);
      for (int t = 0; t < 10; t++)
      begin
         sel = t % 4;
         d = $random(seed);
         cmp = (t % 3 == 0) ? $random(seed) : res[sel];
         apb(1'b1, OFS_SWAP_DATA, d);
         apb(1'b1, OFS_SWAP_CMP, cmp);
         apb(1'b1, OFS_SWAP_CTRL, ({$random(seed)} & 32'hFFFF_FFFC) | sel);
         rd_chk(OFS_SWAP_CTRL, 32'h8000_0000 | sel, "swap control");
         rd_chk(OFS_SWAP_DATA, res[sel], "old value");
         if (cmp === res[sel])
            res[sel] = d;
      end
      check("swap irq", irq, 1'b1);
      rd_chk(OFS_IRQ_STATUS, 32'h1, "swap status");
      // ROM header, bus reads and serial ROM CRC load
      v = $random(seed);
      apb(1'b1, OFS_ROM_HDR, v);
      rd_chk(OFS_ROM_HDR, v, "rom header");
      for (int t = 0; t < 2; t++)
      begin
         cfg_req <= 1'b1;
         cfg_addr <= ROM_HDR_BUS_ADDR + 48'(4 * t);
         @(posedge clk);
         cfg_req <= 1'b0;
         @(posedge clk);
         check("bus hit", cfg_hit, t == 0);
         check("bus data", cfg_data, (t == 0) ? v : 32'h0);
      end
      crc <= 16'($random(seed));
      crc_valid <= 1'b1;
      @(posedge clk);
      crc_valid <= 1'b0;
      rd_chk(OFS_ROM_HDR, {v[31:16], crc}, "crc load");
      apb(1'b1, OFS_LINK_CTRL, 32'h1);
      @(negedge clk);
      check("link active", link, 1'b1);
      rd_chk(OFS_IRQ_STATUS, 32'h10, "crc status");
      rd_chk(OFS_IRQ_STATUS, 32'h0, "status cleared");
      // Second reset without a serial ROM: no presence flag, no CRC load
      strap <= 1'b0;
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      check("link reset", link, 1'b0);
      rd_chk(OFS_VERSION, VERSION_RST, "no rom version");
      crc_valid <= 1'b1;
      @(posedge clk);
      crc_valid <= 1'b0;
      rd_chk(OFS_ROM_HDR, ROM_HDR_RST, "no rom crc");
      rd_chk(OFS_IRQ_STATUS, 32'h0, "no rom status");
      results();
   end
endmodule
